// ===== src/qfr_dev.sv
// Flash-side quad read engine
// Function
// - 6Bh address width follows extended mode; 6Ch four-byte
// - Host sets quad enable before quad-output read
// - Quad-output opcode, address, dummy on line 0
// - Quad-output data nibbles on falling edge, MSB line3
// - Address increments per byte as 32 bits, wraps to zero only past FFFFFFFFh, also for three-byte addresses
// - Chip select high ends read, outputs released
// - Quad-output read ignored while write in progress
// - EBh address width follows extended mode; ECh four-byte
// - Host sets quad enable before quad address read
// - Quad address read address nibbles, MSB line3
// - Quad address read data nibbles, MSB line3
// - Two mode cycles after address, within dummy
// - Upper mode nibble 1010 enters continuous read
// - Other mode nibble leaves continuous read
// - Six dummies means mode plus four more
// - Quad address read ignored while write in progress
// - Host releases lines during don't-care mode nibble only when no dummy follows it
`timescale 1ns/1ps
`default_nettype none
module qfr_dev
  import qfr_pkg::*;
#(
  parameter int FIFO_DEPTH = QFR_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  qfr_if.dev link,
  input wire logic extended_addressing_mode_i,
  input wire logic quad_enable_bit_i,
  input wire logic write_in_progress_flag_i,
  input wire logic [5:0] dummy_qout_i,
  input wire logic [5:0] dummy_qaddr_i,
  output logic [31:0] mem_addr_o,
  output logic mem_req_o,
  input wire logic [7:0] mem_data_i,
  input wire logic mem_valid_i,
  output logic mem_ready_o,
  output logic continuous_read_mode_o,
  output logic busy_o
);
  import qfr_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sck_s_q;
  logic [1:0] cs_s_q;
  logic [3:0] io_m_q;
  logic [3:0] io_s_q;
  logic sck_d1_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sck_s_q <= 2'b00;
      cs_s_q <= 2'b11;
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], link.sck};
      cs_s_q <= {cs_s_q[0], link.cs_n};
      io_m_q <= link.io;
      io_s_q <= io_m_q;
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire sck_s = sck_s_q[1];
  wire cs_n_s = cs_s_q[1];
  wire rise = sck_s && !sck_d1_q;
  wire fall = !sck_s && sck_d1_q;
  ////////////////////////////////////////////////////////////////
  // Data buffer between array and output shifter
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic pop_q;
  qfr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i || cs_n_s),
    .in_valid_i(mem_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(mem_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop_q),
    .out_data_o(fifo_data)
  );
  assign mem_ready_o = fifo_ready;
  ////////////////////////////////////////////////////////////////
  // Command state machine
  qfr_state_e st_q;
  logic quad_q;
  logic [7:0] sh_q;
  logic [31:0] addr_q;
  logic [5:0] cnt_q;
  logic [5:0] alen_q;
  logic [5:0] dum_q;
  logic cont_q;
  logic hi_q;
  logic [7:0] byte_q;
  logic [3:0] dout_q;
  logic oe_q;
  logic [31:0] faddr_q;
  logic [31:0] maddr_q;
  logic req_q;
  logic [7:0] op_next;
  assign op_next = {sh_q[6:0], io_s_q[0]};
  wire is_qout = (op_next == QFR_OP_QOUT) || (op_next == QFR_OP_QOUT_WIDE);
  wire is_qaddr = (op_next == QFR_OP_QADDR) || (op_next == QFR_OP_QADDR_WIDE);
  wire wide_op = (op_next == QFR_OP_QOUT_WIDE) || (op_next == QFR_OP_QADDR_WIDE);
  wire [5:0] alen_sel = (wide_op || extended_addressing_mode_i) ? QFR_BITS_4B : QFR_BITS_3B;
  wire [5:0] nib_len = extended_addressing_mode_i ? QFR_NIB_4B : QFR_NIB_3B;
  wire [31:0] addr_q1 = {addr_q[30:0], io_s_q[0]};
  wire [31:0] addr_q4 = {addr_q[27:0], io_s_q};
  // Fetch queue stays ahead while data streams out
  wire can_req = (st_q == QFR_ST_DUMMY || st_q == QFR_ST_DATA) && fifo_ready && !req_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= QFR_ST_OP;
      quad_q <= 1'b0;
      sh_q <= 8'h00;
      addr_q <= 32'h0;
      cnt_q <= 6'h0;
      alen_q <= QFR_BITS_3B;
      dum_q <= QFR_DUMMY_QOUT_DEF;
      cont_q <= 1'b0;
      hi_q <= 1'b1;
      byte_q <= 8'h00;
      dout_q <= 4'h0;
      oe_q <= 1'b0;
      faddr_q <= 32'h0;
      maddr_q <= 32'h0;
      req_q <= 1'b0;
      pop_q <= 1'b0;
    end else if (cs_n_s) begin
      oe_q <= 1'b0;
      pop_q <= 1'b0;
      req_q <= 1'b0;
      hi_q <= 1'b1;
      cnt_q <= 6'h0;
      sh_q <= 8'h00;
      addr_q <= 32'h0;
      st_q <= cont_q ? QFR_ST_ADDR : QFR_ST_OP;
      quad_q <= cont_q;
      // Continuous read keeps the address width of the command that entered it
      if (!cont_q) begin
        alen_q <= nib_len;
      end
      dum_q <= dummy_qaddr_i;
    end else begin
      pop_q <= 1'b0;
      req_q <= can_req;
      if (can_req) begin
        maddr_q <= faddr_q;
        faddr_q <= faddr_q + 32'h1;
      end
      unique case (st_q)
        QFR_ST_OP: if (rise) begin
          sh_q <= op_next;
          cnt_q <= cnt_q + 6'h1;
          if (cnt_q == QFR_OP_BITS - 6'h1) begin
            cnt_q <= 6'h0;
            alen_q <= is_qaddr ? (alen_sel >> 2) : alen_sel;
            quad_q <= is_qaddr;
            dum_q <= is_qaddr ? dummy_qaddr_i : dummy_qout_i;
            if ((is_qout || is_qaddr) && !write_in_progress_flag_i) begin
              st_q <= QFR_ST_ADDR;
            end else begin
              st_q <= QFR_ST_IGNORE;
            end
          end
        end
        QFR_ST_ADDR: if (rise) begin
          addr_q <= quad_q ? addr_q4 : addr_q1;
          cnt_q <= cnt_q + 6'h1;
          if (cnt_q == alen_q - 6'h1) begin
            cnt_q <= 6'h0;
            faddr_q <= quad_q ? addr_q4 : addr_q1;
            if (quad_q && write_in_progress_flag_i) begin
              st_q <= QFR_ST_IGNORE;
            end else begin
              st_q <= quad_q ? QFR_ST_MODE : QFR_ST_DUMMY;
            end
          end
        end
        QFR_ST_MODE: if (rise) begin
          cnt_q <= cnt_q + 6'h1;
          if (cnt_q == 6'h0) begin
            cont_q <= (io_s_q == QFR_MODE_CONT);
          end
          if (cnt_q == QFR_MODE_CYCLES - 6'h1) begin
            cnt_q <= QFR_MODE_CYCLES;
            st_q <= (dum_q <= QFR_MODE_CYCLES) ? QFR_ST_DATA : QFR_ST_DUMMY;
          end
        end
        QFR_ST_DUMMY: if (rise) begin
          cnt_q <= cnt_q + 6'h1;
          if (cnt_q + 6'h1 >= dum_q) begin
            st_q <= QFR_ST_DATA;
          end
        end
        QFR_ST_DATA: if (fall) begin
          // Nibbles leave MSB first with bit 7 on line 3
          oe_q <= 1'b1;
          if (hi_q) begin
            dout_q <= fifo_data[7:4];
            byte_q <= fifo_data;
            pop_q <= fifo_valid;
          end else begin
            dout_q <= byte_q[3:0];
          end
          hi_q <= !hi_q;
        end
        QFR_ST_IGNORE: begin
          oe_q <= 1'b0;
        end
        default: st_q <= QFR_ST_IGNORE;
      endcase
    end
  end
  assign mem_addr_o = maddr_q;
  assign mem_req_o = req_q;
  assign link.io_dev = dout_q;
  assign link.io_dev_oe = {4{oe_q && !cs_n_s}};
  assign continuous_read_mode_o = cont_q;
  assign busy_o = !cs_n_s;
endmodule // qfr_dev
`default_nettype wire

// ===== common/qfr_pkg.sv
// Shared constants and types for the quad fast read engine
package qfr_pkg;
  localparam logic [7:0] QFR_OP_QOUT = 8'h6B;
  localparam logic [7:0] QFR_OP_QOUT_WIDE = 8'h6C;
  localparam logic [7:0] QFR_OP_QADDR = 8'hEB;
  localparam logic [7:0] QFR_OP_QADDR_WIDE = 8'hEC;
  localparam logic [3:0] QFR_MODE_CONT = 4'hA;
  localparam logic [7:0] QFR_MODE_KEEP = 8'hA0;
  localparam logic [7:0] QFR_MODE_EXIT = 8'hFF;
  localparam logic [5:0] QFR_DUMMY_QOUT_DEF = 6'h08;
  localparam logic [5:0] QFR_DUMMY_QADDR_DEF = 6'h06;
  localparam logic [5:0] QFR_MODE_CYCLES = 6'h02;
  localparam logic [5:0] QFR_OP_BITS = 6'h08;
  localparam logic [5:0] QFR_BITS_3B = 6'h18;
  localparam logic [5:0] QFR_BITS_4B = 6'h20;
  localparam logic [5:0] QFR_NIB_3B = 6'h06;
  localparam logic [5:0] QFR_NIB_4B = 6'h08;
  localparam int QFR_ADDR_W = 32;
  localparam int QFR_FIFO_DEPTH = 8;
  localparam int QFR_SCK_DIV = 8;
  typedef enum logic [2:0] {
    QFR_ST_OP = 3'b000,
    QFR_ST_ADDR = 3'b001,
    QFR_ST_MODE = 3'b010,
    QFR_ST_DUMMY = 3'b011,
    QFR_ST_DATA = 3'b100,
    QFR_ST_IGNORE = 3'b101
  } qfr_state_e;
endpackage

// ===== common/qfr_if.sv
// Quad SPI link between host controller and flash read engine
`timescale 1ns/1ps
`default_nettype none
interface qfr_if;
  logic sck;
  logic cs_n;
  logic [3:0] io_host;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev;
  logic [3:0] io_dev_oe;
  logic [3:0] io;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_res
    assign io[g] = io_dev_oe[g] ? io_dev[g] : (io_host_oe[g] ? io_host[g] : 1'b1);
  end
  modport dev (input sck, input cs_n, input io, output io_dev, output io_dev_oe);
  modport host (output sck, output cs_n, input io, output io_host, output io_host_oe);
endinterface
`default_nettype wire

// ===== src/qfr_fifo.sv
// Flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module qfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule // qfr_fifo
`default_nettype wire

// ===== src/qfr_host.sv
// Host-side quad read controller
`timescale 1ns/1ps
`default_nettype none
module qfr_host
  import qfr_pkg::*;
#(
  parameter int SCK_DIV = QFR_SCK_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  qfr_if.host link,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [31:0] addr_i,
  input wire logic wide_addr_i,
  input wire logic [5:0] dummy_i,
  input wire logic [7:0] mode_i,
  input wire logic skip_op_i,
  input wire logic [7:0] len_i,
  output logic [7:0] data_o,
  output logic data_valid_o,
  output logic busy_o
);
  import qfr_pkg::*;
  qfr_state_e st_q;
  logic [7:0] div_q;
  logic sck_q;
  logic cs_n_q;
  logic [7:0] op_q;
  logic [31:0] addr_q;
  logic [7:0] mode_q;
  logic [5:0] cnt_q;
  logic [5:0] alen_q;
  logic [5:0] dum_q;
  logic quad_q;
  logic [7:0] left_q;
  logic [3:0] hi_nib_q;
  logic hi_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [7:0] data_q;
  logic dv_q;
  logic [3:0] io_m_q;
  logic [3:0] io_s_q;
  wire tick = (div_q == 8'(SCK_DIV/2 - 1));
  wire fall_t = tick && sck_q;
  wire is_q = (opcode_i == QFR_OP_QADDR) || (opcode_i == QFR_OP_QADDR_WIDE);
  wire [5:0] bits = wide_addr_i ? QFR_BITS_4B : QFR_BITS_3B;
  // Short addresses move to the top so shifting always starts at bit 31
  wire [31:0] addr_al = wide_addr_i ? addr_i : {addr_i[23:0], 8'h00};
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      io_m_q <= link.io;
      io_s_q <= io_m_q;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= QFR_ST_IGNORE;
      div_q <= 8'h0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      op_q <= 8'h0;
      addr_q <= 32'h0;
      mode_q <= 8'h0;
      cnt_q <= 6'h0;
      alen_q <= 6'h0;
      dum_q <= 6'h0;
      quad_q <= 1'b0;
      left_q <= 8'h0;
      hi_nib_q <= 4'h0;
      hi_q <= 1'b1;
      out_q <= 4'h0;
      oe_q <= 4'h0;
      data_q <= 8'h0;
      dv_q <= 1'b0;
    end else begin
      dv_q <= 1'b0;
      div_q <= (cs_n_q || tick) ? 8'h0 : div_q + 8'h1;
      if (cs_n_q) begin
        sck_q <= 1'b0;
        if (start_i) begin
          // Quad enable must already be set by the caller
          cs_n_q <= 1'b0;
          op_q <= opcode_i;
          addr_q <= addr_al;
          mode_q <= mode_i;
          quad_q <= is_q;
          alen_q <= is_q ? (bits >> 2) : bits;
          dum_q <= dummy_i;
          left_q <= len_i;
          cnt_q <= 6'h0;
          hi_q <= 1'b1;
          st_q <= (skip_op_i && is_q) ? QFR_ST_ADDR : QFR_ST_OP;
          out_q <= (skip_op_i && is_q) ? addr_al[31:28] : {3'b000, opcode_i[7]};
          oe_q <= (skip_op_i && is_q) ? 4'hF : 4'h1;
        end
      end else if (tick) begin
        sck_q <= !sck_q;
        if (fall_t) begin
          cnt_q <= cnt_q + 6'h1;
          unique case (st_q)
            QFR_ST_OP: begin
              op_q <= {op_q[6:0], 1'b0};
              out_q <= {3'b000, op_q[6]};
              if (cnt_q == QFR_OP_BITS - 6'h1) begin
                cnt_q <= 6'h0;
                st_q <= QFR_ST_ADDR;
                out_q <= quad_q ? addr_q[31:28] : {3'b000, addr_q[31]};
                oe_q <= quad_q ? 4'hF : 4'h1;
              end
            end
            QFR_ST_ADDR: begin
              addr_q <= quad_q ? {addr_q[27:0], 4'h0} : {addr_q[30:0], 1'b0};
              out_q <= quad_q ? addr_q[27:24] : {3'b000, addr_q[30]};
              if (cnt_q == alen_q - 6'h1) begin
                cnt_q <= 6'h0;
                st_q <= quad_q ? QFR_ST_MODE : QFR_ST_DUMMY;
                out_q <= quad_q ? mode_q[7:4] : 4'h0;
              end
            end
            QFR_ST_MODE: begin
              out_q <= mode_q[3:0];
              // Lower nibble released when no dummy follows it
              oe_q <= (dum_q <= QFR_MODE_CYCLES) ? 4'h0 : 4'hF;
              if (cnt_q == QFR_MODE_CYCLES - 6'h1) begin
                oe_q <= 4'h0;
                st_q <= (dum_q <= QFR_MODE_CYCLES) ? QFR_ST_DATA : QFR_ST_DUMMY;
              end
            end
            QFR_ST_DUMMY: begin
              oe_q <= 4'h0;
              if (cnt_q + 6'h1 >= dum_q) begin
                st_q <= QFR_ST_DATA;
              end
            end
            QFR_ST_DATA: begin
              // Synchronised return path lags more than half a period, so a nibble is
              // taken at the fall that ends it, before the device moves on
              if (hi_q) begin
                hi_nib_q <= io_s_q;
              end else begin
                data_q <= {hi_nib_q, io_s_q};
                dv_q <= 1'b1;
                left_q <= left_q - 8'h1;
                if (left_q == 8'h0) begin
                  cs_n_q <= 1'b1;
                  st_q <= QFR_ST_IGNORE;
                end
              end
              hi_q <= !hi_q;
            end
            default: st_q <= QFR_ST_IGNORE;
          endcase
        end
      end
    end
  end
  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.io_host = out_q;
  assign link.io_host_oe = cs_n_q ? 4'h0 : oe_q;
  assign data_o = data_q;
  assign data_valid_o = dv_q;
  assign busy_o = !cs_n_q;
endmodule // qfr_host
`default_nettype wire

// ===== sim/qfr_monitor.sv
// Checker watching the quad link between the two ends
`timescale 1ns/1ps
`default_nettype none
module qfr_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_host,
  input wire logic [3:0] io_host_oe,
  input wire logic [3:0] io_dev,
  input wire logic [3:0] io_dev_oe
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_select;
    $fell(cs_n);
  endsequence
  sequence s_dev_quiet;
    (io_dev_oe == 4'h0) [*8];
  endsequence
  AST_DEV_QUIET_OPENING: assert property (s_select |-> s_dev_quiet)
    else $error("device drove lines during the command opening");
  AST_CS_RELEASE: assert property (cs_n [*6] |-> io_dev_oe == 4'h0)
    else $error("device still drives while deselected");
  AST_NO_CONTENTION: assert property ((io_dev_oe & io_host_oe) == 4'h0)
    else $error("both ends drive a line");
  AST_DEV_OE_QUAD: assert property (io_dev_oe inside {4'h0, 4'hF})
    else $error("device drives a partial nibble");
  AST_HOST_OE_SHAPE: assert property (io_host_oe inside {4'h0, 4'h1, 4'hF})
    else $error("host drives an unexpected line set");
  AST_DEV_CHANGE_LOW: assert property ($changed(io_dev) && io_dev_oe != 4'h0
    && $past(io_dev_oe) != 4'h0 |-> !sck)
    else $error("device data changed while clock high");
  AST_DEV_HOLD_RISE: assert property ($rose(sck) && io_dev_oe == 4'hF |-> $stable(io_dev))
    else $error("device data moved at clock rise");
  AST_HOST_HOLD_RISE: assert property ($rose(sck) && io_host_oe != 4'h0
    |-> $stable(io_host) && $stable(io_host_oe))
    else $error("host data moved at clock rise");
  AST_SCK_SELECTED: assert property ($rose(sck) |-> !cs_n)
    else $error("clock pulsed while deselected");
endmodule // qfr_monitor
`default_nettype wire

// ===== sim/quad_fast_read_engine_tb.sv
// Self-checking bench joining host and flash ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s exp=%h got=%h", nm, exp, got); end end
module quad_fast_read_engine_tb;
  import qfr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext = 1'b0, write_in_progress_flag = 1'b0, start = 1'b0, wide = 1'b0, skip = 1'b0, sck_d = 1'b0;
  logic [5:0] dq = QFR_DUMMY_QOUT_DEF, da = QFR_DUMMY_QADDR_DEF, dm = 6'h00;
  logic [7:0] op = 8'h00, md = 8'h00, ln = 8'h00, m_dat = 8'h00, op_sh = 8'h00, o_r;
  logic [31:0] ad = 32'h0;
  logic [31:0] m_addr;
  logic m_req, m_rdy, cont, dbusy, hbusy, dv;
  logic m_val = 1'b0;
  logic [7:0] dat;
  logic [7:0] ops [4] = '{QFR_OP_QOUT, QFR_OP_QOUT_WIDE, QFR_OP_QADDR, QFR_OP_QADDR_WIDE};
  int err_count = 0, checks = 0, seed = 64, nb = 0, i;
  qfr_if lk ();
  qfr_dev u_qfr_dev (.clk_sys_i(clk), .rst_i(rst), .link(lk.dev),
    .extended_addressing_mode_i(ext), .write_in_progress_flag_i(write_in_progress_flag),
    .quad_enable_bit_i(1'b1),
    .dummy_qout_i(dq), .dummy_qaddr_i(da), .mem_addr_o(m_addr), .mem_req_o(m_req),
    .mem_data_i(m_dat), .mem_valid_i(m_val), .mem_ready_o(m_rdy),
    .continuous_read_mode_o(cont), .busy_o(dbusy));
  qfr_host u_qfr_host (.clk_sys_i(clk), .rst_i(rst), .link(lk.host), .start_i(start),
    .opcode_i(op), .addr_i(ad), .wide_addr_i(wide), .dummy_i(dm), .mode_i(md), .skip_op_i(skip),
    .len_i(ln), .data_o(dat), .data_valid_o(dv), .busy_o(hbusy));
  qfr_monitor u_qfr_monitor (.clk_sys_i(clk), .rst_i(rst), .sck(lk.sck), .cs_n(lk.cs_n),
    .io_host(lk.io_host), .io_host_oe(lk.io_host_oe), .io_dev(lk.io_dev),
    .io_dev_oe(lk.io_dev_oe));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fb(input logic [31:0] a);
    return a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  // Array model answers each fetch with a byte derived from its address
  always @(posedge clk) begin
    if (rst) m_val <= 1'b0;
    else if (m_req) begin
      m_val <= 1'b1;
      m_dat <= fb(m_addr);
    end else if (m_rdy) m_val <= 1'b0;
  end
  // Collects the first eight line-0 bits of each frame
  always @(posedge clk) begin
    sck_d <= lk.sck;
    if (lk.cs_n) nb <= 0;
    else if (lk.sck && !sck_d && nb < 8) begin
      op_sh <= {op_sh[6:0], lk.io[0]};
      nb <= nb + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [7:0] o, input logic [31:0] a, input logic w,
      input logic [5:0] d, input logic [7:0] m, input logic s, input logic [7:0] l,
      input logic bad);
    int n;
    int t;
    logic [31:0] ea;
    n = 0;
    t = 0;
    ea = w ? a : {8'h00, a[23:0]};
    op = o;
    ad = a;
    wide = w;
    dm = d;
    md = m;
    skip = s;
    ln = l;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    do begin
      @(negedge clk);
      t++;
      if (dv === 1'b1) begin
        `CHK("read_byte", bad ? 8'hFF : fb(ea + n), dat)
        n++;
      end
    end while (hbusy === 1'b1 && t < 20000);
    `CHK("byte_count", int'(l) + 1, n)
    if (!s) `CHK("opcode_wire", o, op_sh)
    repeat (8) @(negedge clk);
    `CHK("dev_idle", 1'b0, dbusy)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    // Every opcode in both address modes, random start and length
    for (i = 0; i < 16; i++) begin
      ext = i[2];
      o_r = ops[i[1:0]];
      rd(o_r, $random(seed), ext | ~o_r[0], o_r[7] ? da : dq, QFR_MODE_EXIT, 1'b0,
        8'($random(seed)) & 8'h1F, 1'b0);
    end
    ext = 1'b0;
    rd(QFR_OP_QOUT_WIDE, 32'hFFFFFFFE, 1'b1, dq, QFR_MODE_EXIT, 1'b0, 8'h03, 1'b0);
    rd(QFR_OP_QADDR_WIDE, 32'hFFFFFFFF, 1'b1, da, QFR_MODE_EXIT, 1'b0, 8'h01, 1'b0);
    rd(QFR_OP_QADDR, 32'h00ABCDEF, 1'b0, da, QFR_MODE_EXIT, 1'b0, 8'h27, 1'b0);
    // Non-default dummy counts on both commands
    dq = 6'h0A;
    da = 6'h04;
    rd(QFR_OP_QOUT, $random(seed), 1'b0, dq, QFR_MODE_EXIT, 1'b0, 8'h05, 1'b0);
    rd(QFR_OP_QADDR, $random(seed), 1'b0, da, QFR_MODE_EXIT, 1'b0, 8'h05, 1'b0);
    dq = QFR_DUMMY_QOUT_DEF;
    da = QFR_DUMMY_QADDR_DEF;
    // Continuous read entry, repeat without opcode, then exit
    rd(QFR_OP_QADDR_WIDE, $random(seed), 1'b1, da, 8'hA5, 1'b0, 8'h03, 1'b0);
    `CHK("cont_enter", 1'b1, cont)
    rd(QFR_OP_QADDR_WIDE, $random(seed), 1'b1, da, QFR_MODE_KEEP, 1'b1, 8'h02, 1'b0);
    `CHK("cont_keep", 1'b1, cont)
    rd(QFR_OP_QADDR_WIDE, $random(seed), 1'b1, da, 8'h5F, 1'b1, 8'h02, 1'b0);
    `CHK("cont_exit", 1'b0, cont)
    rd(QFR_OP_QADDR, $random(seed), 1'b0, da, QFR_MODE_KEEP, 1'b0, 8'h02, 1'b0);
    `CHK("cont_again", 1'b1, cont)
    rd(QFR_OP_QADDR, $random(seed), 1'b0, da, QFR_MODE_EXIT, 1'b1, 8'h01, 1'b0);
    `CHK("cont_leave", 1'b0, cont)
    // Reads refused while a write cycle runs
    write_in_progress_flag = 1'b1;
    rd(QFR_OP_QOUT, $random(seed), 1'b0, dq, QFR_MODE_EXIT, 1'b0, 8'h03, 1'b1);
    rd(QFR_OP_QADDR, $random(seed), 1'b0, da, QFR_MODE_KEEP, 1'b0, 8'h03, 1'b1);
    `CHK("wip_cont", 1'b0, cont)
    write_in_progress_flag = 1'b0;
    rd(QFR_OP_QOUT, $random(seed), 1'b0, dq, QFR_MODE_EXIT, 1'b0, 8'h03, 1'b0);
    summarize();
  end
endmodule // quad_fast_read_engine_tb
`default_nettype wire
